// *** src/volume_ramp_automute.sv ***
`timescale 1ns/1ns
`include "vramp_defs.svh"

module volume_ramp_automute #(
  parameter int CNT_W = 19
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rstn,
  input  wire logic [7:0]            regAddr,
  input  wire logic [7:0]            regWrData,
  input  wire logic                  regWrite,
  output logic      [7:0]            regRdData,
  input  wire logic [7:0]            targetLevel,
  input  wire logic                  emergencyDown,
  input  wire logic                  sampleTick,
  input  wire vramp_pkg::vramp_sample_t sampleIn,
  output logic      [7:0]            volumeLevel,
  output vramp_pkg::vramp_mute_t     channelMute
);

  // sample count for a silence time code
  function automatic logic [CNT_W-1:0] silenceCount(input logic [2:0] code);
    logic [31:0] n;
    n = 32'h0;
    unique case (code)
      3'h0: n = `VRAMP_US_TO_SAMPLES(`VRAMP_T0_US);
      3'h1: n = `VRAMP_US_TO_SAMPLES(`VRAMP_T1_US);
      3'h2: n = `VRAMP_US_TO_SAMPLES(`VRAMP_T2_US);
      3'h3: n = `VRAMP_US_TO_SAMPLES(`VRAMP_T3_US);
      3'h4: n = `VRAMP_US_TO_SAMPLES(`VRAMP_T4_US);
      3'h5: n = `VRAMP_US_TO_SAMPLES(`VRAMP_T5_US);
      3'h6: n = `VRAMP_US_TO_SAMPLES(`VRAMP_T6_US);
      3'h7: n = `VRAMP_US_TO_SAMPLES(`VRAMP_T7_US);
    endcase
    return n[CNT_W-1:0];
  endfunction : silenceCount

  // step code to half-dB codes: 4, 2, 1, 0.5 dB
  function automatic logic [7:0] stepSize(input logic [1:0] code);
    return 8'h08 >> code;
  endfunction : stepSize

  // control registers, every bit kept and read back
  logic [7:0] normalRamp;
  logic [7:0] emergRamp;
  logic [7:0] silenceCtrl;
  logic [7:0] silenceTime;

  // register writes, reserved bits kept as written
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      normalRamp  <= `VRAMP_RST_NORMAL_RAMP;
      emergRamp   <= `VRAMP_RST_EMERG_RAMP;
      silenceCtrl <= `VRAMP_RST_SILENCE_CTRL;
      silenceTime <= `VRAMP_RST_SILENCE_TIME;
    end
    else if (regWrite)
    begin
      if (regAddr == `VRAMP_OFS_NORMAL_RAMP)  normalRamp  <= regWrData;
      if (regAddr == `VRAMP_OFS_EMERG_RAMP)   emergRamp   <= regWrData;
      if (regAddr == `VRAMP_OFS_SILENCE_CTRL) silenceCtrl <= regWrData;
      if (regAddr == `VRAMP_OFS_SILENCE_TIME) silenceTime <= regWrData;
    end
  end

  // read mux, unmapped reads zero
  wire logic [7:0] next_regRdData =
    (regAddr == `VRAMP_OFS_NORMAL_RAMP)  ? normalRamp  :
    (regAddr == `VRAMP_OFS_EMERG_RAMP)   ? emergRamp   :
    (regAddr == `VRAMP_OFS_SILENCE_CTRL) ? silenceCtrl :
    (regAddr == `VRAMP_OFS_SILENCE_TIME) ? silenceTime : 8'h00;

  // read data follows regAddr one cycle later
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn) regRdData <= 8'h00;
    else       regRdData <= next_regRdData;
  end

  // ramp target and field selection
  // clamp target
  wire logic [7:0] userTarget = (targetLevel > `VRAMP_VOL_MIN) ? `VRAMP_VOL_ZERO : targetLevel;
  // emergency forces the silent code whatever the user set
  wire logic [7:0] rampTarget = emergencyDown ? `VRAMP_VOL_ZERO : userTarget;
  wire logic       goDown     = volumeLevel < rampTarget;
  wire logic       goUp       = volumeLevel > rampTarget;
  wire logic [1:0] downIntv   = emergencyDown
                                ? emergRamp[`VRAMP_DOWN_INTERVAL_MSB -: 2]
                                : normalRamp[`VRAMP_DOWN_INTERVAL_MSB -: 2];
  wire logic [1:0] downIncr   = emergencyDown
                                ? emergRamp[`VRAMP_DOWN_INCR_MSB -: 2]
                                : normalRamp[`VRAMP_DOWN_INCR_MSB -: 2];
  wire logic [1:0] upIntv     = normalRamp[`VRAMP_UP_INTERVAL_MSB -: 2];
  wire logic [1:0] upIncr     = normalRamp[`VRAMP_UP_INCR_MSB -: 2];
  wire logic [1:0] activeIntv = goDown ? downIntv : upIntv;
  // interval code 11 jumps instead of stepping
  wire logic       instant    = (activeIntv == 2'b11);

  // direction state and ticks seen since the last update
  vramp_pkg::vramp_state_t rampState;
  logic [1:0]              tickCount;

  // direction from where the volume sits against its target
  wire vramp_pkg::vramp_state_t next_rampState =
    goDown ? vramp_pkg::VRAMP_DOWN : (goUp ? vramp_pkg::VRAMP_UP : vramp_pkg::VRAMP_HOLD);
  // a new direction restarts the interval count
  wire logic dirChange = (next_rampState != rampState);

  // the tick ending an interval updates and restarts the count
  // update interval
  wire logic [1:0] intvLast  = (2'b01 << activeIntv) - 2'b01;
  wire logic       updateDue = sampleTick && (dirChange ? (activeIntv == 2'b00)
                                                          : (tickCount >= intvLast));

  wire logic [8:0] downSum  = {1'b0, volumeLevel} + {1'b0, stepSize(downIncr)};
  wire logic [7:0] downNext = (downSum >= {1'b0, rampTarget}) ? rampTarget : downSum[7:0];
  wire logic [7:0] upStep   = stepSize(upIncr);
  // nine-bit reach so a target near the bottom cannot wrap
  wire logic [8:0] upReach  = {1'b0, rampTarget} + {1'b0, upStep};
  wire logic [7:0] upNext   = ({1'b0, volumeLevel} <= upReach) ? rampTarget
                                                                : volumeLevel - upStep;

  // next volume: instant codes jump, otherwise step on due updates
  wire logic [7:0] next_volumeLevel =
    (goDown && instant && sampleTick) ? `VRAMP_VOL_ZERO :
    (goUp   && instant && sampleTick) ? rampTarget :
    (goDown && updateDue)             ? downNext   :
    (goUp   && updateDue)             ? upNext     : volumeLevel;

  // tickCount moves only on ticks, so idle cycles never shorten an interval
  // ramp state, interval counter and volume
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rampState   <= vramp_pkg::VRAMP_HOLD;
      tickCount   <= 2'h0;
      volumeLevel <= `VRAMP_VOL_ZERO;
    end
    else
    begin
      rampState   <= next_rampState;
      volumeLevel <= next_volumeLevel;
      if (dirChange || updateDue) tickCount <= 2'h0;
      else if (sampleTick)        tickCount <= tickCount + 2'h1;
    end
  end

  // silence detection per channel
  // left time field
  wire logic [CNT_W-1:0] leftLimit  = silenceCount(silenceTime[`VRAMP_LEFT_TIME_MSB -: 3]);
  wire logic [CNT_W-1:0] rightLimit = silenceCount(silenceTime[`VRAMP_RIGHT_TIME_MSB -: 3]);
  wire logic             leftZero   = (sampleIn.left == 24'h000000);
  wire logic             rightZero  = (sampleIn.right == 24'h000000);

  // zero-sample run length per channel, saturating at its limit
  logic [CNT_W-1:0] leftCount;
  logic [CNT_W-1:0] rightCount;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      leftCount  <= '0;
      rightCount <= '0;
    end
    else if (sampleTick)
    begin
      if (!leftZero)                  leftCount  <= '0;
      else if (leftCount < leftLimit) leftCount  <= leftCount + CNT_W'(1);
      if (!rightZero)                   rightCount <= '0;
      else if (rightCount < rightLimit) rightCount <= rightCount + CNT_W'(1);
    end
  end

  wire logic leftQual  = silenceCtrl[`VRAMP_LEFT_ENABLE_BIT] && (leftCount >= leftLimit);
  wire logic rightQual = silenceCtrl[`VRAMP_RIGHT_ENABLE_BIT] && (rightCount >= rightLimit);
  wire logic joint     = silenceCtrl[`VRAMP_JOINT_BIT];
  // joint mode holds both until both qualify
  wire vramp_pkg::vramp_mute_t next_channelMute =
    joint ? {leftQual && rightQual, leftQual && rightQual} : {leftQual, rightQual};

  // mute outputs
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn) channelMute <= '0;
    else       channelMute <= next_channelMute;
  end

endmodule : volume_ramp_automute

// *** src/vramp_defs.svh ***
`ifndef VRAMP_DEFS_SVH
`define VRAMP_DEFS_SVH

// register offsets
`define VRAMP_OFS_NORMAL_RAMP    8'h4E
`define VRAMP_OFS_EMERG_RAMP     8'h4F
`define VRAMP_OFS_SILENCE_CTRL   8'h50
`define VRAMP_OFS_SILENCE_TIME   8'h51

// reset values
`define VRAMP_RST_NORMAL_RAMP    8'h33
`define VRAMP_RST_EMERG_RAMP     8'h30
`define VRAMP_RST_SILENCE_CTRL   8'h07
`define VRAMP_RST_SILENCE_TIME   8'h00

// field positions (msb of two- and three-bit fields, index of single-bit fields)
`define VRAMP_DOWN_INTERVAL_MSB  7
`define VRAMP_DOWN_INCR_MSB      5
`define VRAMP_UP_INTERVAL_MSB    3
`define VRAMP_UP_INCR_MSB        1
`define VRAMP_LEFT_ENABLE_BIT    0
`define VRAMP_RIGHT_ENABLE_BIT   1
`define VRAMP_JOINT_BIT          2
`define VRAMP_LEFT_TIME_MSB      6
`define VRAMP_RIGHT_TIME_MSB     2

// volume codes: 0x00 is +24 dB, each code 0.5 dB lower, 0xFE is -103 dB
`define VRAMP_VOL_MAX            8'h00
`define VRAMP_VOL_MIN            8'hFE
`define VRAMP_VOL_ZERO           8'hFF

// silence durations in microseconds, at the reference sample rate in Hz
`define VRAMP_REF_RATE_HZ        96000
`define VRAMP_T0_US              11500
`define VRAMP_T1_US              53000
`define VRAMP_T2_US              106500
`define VRAMP_T3_US              266500
`define VRAMP_T4_US              535000
`define VRAMP_T5_US              1065000
`define VRAMP_T6_US              2665000
`define VRAMP_T7_US              5330000
`define VRAMP_US_TO_SAMPLES(t)   (((t) * (`VRAMP_REF_RATE_HZ / 1000)) / 1000)

`endif

// *** src/vramp_pkg.sv ***
package vramp_pkg;

  // ramp direction states, gray along hold -> down -> up
  typedef enum logic [1:0] {
    VRAMP_HOLD = 2'b00,
    VRAMP_DOWN = 2'b01,
    VRAMP_UP   = 2'b11
  } vramp_state_t;

  // one stereo sample
  typedef struct packed {
    logic [23:0] left;
    logic [23:0] right;
  } vramp_sample_t;

  // per-channel mute pair
  typedef struct packed {
    logic left;
    logic right;
  } vramp_mute_t;

endpackage : vramp_pkg

// *** testbench/volume_ramp_automute_tb.sv ***
`timescale 1ns/1ns
module volume_ramp_automute_tb;
  logic                     sys_clk = 1'b0;
  logic                     rstn = 1'b0;
  logic                     emergencyDown = 1'b0;
  logic                     sampleTick = 1'b0;
  logic                     regWrite;
  logic [7:0]               regAddr, regWrData, regRdData, volumeLevel, rv;
  logic [7:0]               targetLevel = 8'h10;
  logic [7:0]               ofs [5] = '{8'h4E, 8'h4F, 8'h50, 8'h51, 8'h52};
  logic [7:0]               rst [5] = '{8'h33, 8'h30, 8'h07, 8'h00, 8'h00};
  vramp_pkg::vramp_sample_t sampleIn = '0;
  vramp_pkg::vramp_mute_t   channelMute;
  int                       nErrors = 0;
  int                       cmpCount = 0;
  always #20 sys_clk = ~sys_clk;
  volume_ramp_automute dut_u (.sys_clk, .rstn, .regAddr, .regWrData, .regWrite, .regRdData,
    .targetLevel, .emergencyDown, .sampleTick, .sampleIn, .volumeLevel, .channelMute);
  vramp_host_model host_u (.sys_clk, .regRdData, .regAddr, .regWrData, .regWrite);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmpCount++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      nErrors++;
    end
  endtask : chk
  // n isolated ticks, sample only valid while the tick is high
  task automatic tk(input int n, input logic [47:0] s);
    repeat (n)
    begin
      @(negedge sys_clk);
      sampleTick = 1'b1;
      sampleIn = s;
      @(negedge sys_clk);
      sampleTick = 1'b0;
      sampleIn = ~s;
    end
    @(negedge sys_clk);
  endtask : tk
  task automatic summarize();
    if (nErrors == 0 && cmpCount > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  // watchdog, run needs about 17000 cycles
  initial
  begin
    #2000000;
    nErrors++;
    summarize();
  end
  initial
  begin
    repeat (11) @(negedge sys_clk);
    rstn = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      host_u.rd(ofs[i], rv);
      chk(rv, rst[i]);
    end
    host_u.wr(8'h4F, 8'hCF);
    host_u.rd(8'h4F, rv);
    chk(rv, 8'hCF);
    host_u.wr(8'h4E, 8'h00);
    tk(1, 48'h1);
    chk(volumeLevel, 8'hF7);
    tk(30, 48'h1);
    chk(volumeLevel, 8'h10);
    targetLevel = 8'h15;
    host_u.wr(8'h4E, 8'h20);
    tk(1, 48'h1);
    chk(volumeLevel, 8'h12);
    tk(2, 48'h1);
    chk(volumeLevel, 8'h15);
    host_u.wr(8'h4E, 8'hF0);
    targetLevel = 8'h40;
    tk(1, 48'h1);
    chk(volumeLevel, 8'hFF);
    host_u.wr(8'h4E, 8'h0C);
    tk(1, 48'h1);
    chk(volumeLevel, 8'h40);
    host_u.wr(8'h4F, 8'h10);
    emergencyDown = 1'b1;
    tk(1, 48'h1);
    chk(volumeLevel, 8'h44);
    host_u.wr(8'h4F, 8'hC0);
    tk(1, 48'h1);
    chk(volumeLevel, 8'hFF);
    emergencyDown = 1'b0;
    host_u.wr(8'h4E, 8'h0B);
    tk(3, 48'h1);
    chk(volumeLevel, 8'hFF);
    tk(1, 48'h1);
    chk(volumeLevel, 8'hFE);
    targetLevel = 8'hFF;
    host_u.wr(8'h4E, 8'h70);
    tk(1, 48'h1);
    chk(volumeLevel, 8'hFE);
    tk(1, 48'h1);
    chk(volumeLevel, 8'hFF);
    host_u.wr(8'h50, 8'h01);
    tk(1, 48'h000001_000001);
    tk(1103, 48'h000000_000001);
    chk({6'h00, channelMute}, 8'h00);
    tk(1, 48'h000000_000001);
    chk({6'h00, channelMute}, 8'h02);
    tk(1, 48'h000001_000001);
    chk({6'h00, channelMute}, 8'h00);
    host_u.wr(8'h50, 8'h07);
    tk(1104, 48'h000000_000001);
    chk({6'h00, channelMute}, 8'h00);
    tk(1104, 48'h0);
    chk({6'h00, channelMute}, 8'h03);
    host_u.wr(8'h50, 8'h02);
    tk(1, 48'h0);
    chk({6'h00, channelMute}, 8'h01);
    host_u.wr(8'h51, 8'h10);
    host_u.wr(8'h50, 8'h03);
    tk(1, 48'h000001_000001);
    tk(1104, 48'h0);
    chk({6'h00, channelMute}, 8'h01);
    tk(3983, 48'h0);
    chk({6'h00, channelMute}, 8'h01);
    tk(1, 48'h0);
    chk({6'h00, channelMute}, 8'h03);
    summarize();
  end
endmodule : volume_ramp_automute_tb

// *** testbench/vramp_host_model.sv ***
`timescale 1ns/1ns
module vramp_host_model (
  input  wire logic [7:0] regRdData,
  input  wire logic       sys_clk,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWrData,
  output logic            regWrite
);
  initial
  begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrite = 1'b0;
  end
  // one-cycle write strobe, data scrambled once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    regAddr = a;
    regWrData = d;
    regWrite = 1'b1;
    @(negedge sys_clk);
    regWrite = 1'b0;
    regWrData = ~d;
  endtask : wr
  // read data is registered, so let two edges pass
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    regAddr = a;
    repeat (2) @(negedge sys_clk);
    d = regRdData;
  endtask : rd
endmodule : vramp_host_model

// *** testbench/vramp_props.sv ***
`timescale 1ns/1ns
module vramp_props (
  input wire logic                     sys_clk,
  input wire logic                     rstn,
  input wire logic [7:0]               regAddr,
  input wire logic [7:0]               regWrData,
  input wire logic                     regWrite,
  input wire logic [7:0]               targetLevel,
  input wire logic                     emergencyDown,
  input wire logic                     sampleTick,
  input wire vramp_pkg::vramp_sample_t sampleIn,
  input wire logic [7:0]               volumeLevel,
  input wire vramp_pkg::vramp_mute_t   channelMute
);
  logic [2:0]  muteCtrl;
  logic [10:0] zeroRun;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // shadow of the mute control field
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn) muteCtrl <= 3'h7;
    else if (regWrite && regAddr == 8'h50) muteCtrl <= regWrData[2:0];
  // saturating run of zero left samples
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn) zeroRun <= 11'h000;
    else if (sampleTick) zeroRun <= (|sampleIn.left) ? 11'h000 : zeroRun + {10'h000, ~&zeroRun};
  a_idle_hold: assert property (!sampleTick ##1 !sampleTick |=> $stable(volumeLevel))
    else $error("volume moved without tick");
  a_up_clamp: assert property ($past(volumeLevel) >= targetLevel && !emergencyDown
    && $stable(emergencyDown) && $past(targetLevel, 2) == targetLevel |-> volumeLevel >= targetLevel)
    else $error("volume passed target");
  a_left_off: assert property (!muteCtrl[0] ##1 !muteCtrl[0] |-> !channelMute.left)
    else $error("left muted while disabled");
  a_right_off: assert property (!muteCtrl[1] ##1 !muteCtrl[1] |-> !channelMute.right)
    else $error("right muted while disabled");
  a_joint_rise: assert property ($past(muteCtrl[2]) && ($rose(channelMute.left)
    || $rose(channelMute.right)) |-> &channelMute) else $error("joint mute split");
  a_left_release: assert property (sampleTick && |sampleIn.left |-> ##[1:2] !channelMute.left)
    else $error("left mute kept");
  a_right_release: assert property (sampleTick && |sampleIn.right |-> ##[1:2] !channelMute.right)
    else $error("right mute kept");
  a_left_min_run: assert property ($rose(channelMute.left) |-> zeroRun >= 11'h450)
    else $error("left muted too early");
endmodule : vramp_props
bind volume_ramp_automute vramp_props chk_u (.sys_clk, .rstn, .regAddr, .regWrData, .regWrite,
  .targetLevel, .emergencyDown, .sampleTick, .sampleIn, .volumeLevel, .channelMute);
